/* src/bram_pkg.sv */
// Shared constants and types for the dual-port block memory
package bram_pkg;

   // ==========================================================
   // Geometry
   localparam int          WORD_W     = 72;
   localparam int          DATA_W     = 64;
   localparam int          CHK_W      = 8;
   localparam int          ADDR_W     = 15;
   localparam int          IDX_W      = 9;
   localparam int          LVL_W      = 16;
   localparam int          HALF_IDX_W = 8;
   localparam int          NARROW_LOG = 15;
   localparam int          BYTE_LOG   = 12;
   localparam logic [15:0] CAP_NARROW = 16'h8000;
   localparam logic [15:0] CAP_BYTE   = 16'h9000;

   // ==========================================================
   // Reset values
   localparam logic [71:0] DOUT_RST  = 72'h0;
   localparam logic [15:0] LVL_RST   = 16'h0;
   localparam logic [14:0] PTR_RST   = 15'h0;
   localparam logic [7:0]  CHK_RST   = 8'h0;
   localparam logic [63:0] XDATA_RST = 64'h0;

   // ==========================================================
   // Types
   typedef enum logic [2:0] {
      BW_1  = 3'h0,
      BW_2  = 3'h1,
      BW_4  = 3'h2,
      BW_9  = 3'h3,
      BW_18 = 3'h4,
      BW_36 = 3'h5,
      BW_72 = 3'h6
   } bram_width_t;

   typedef enum logic [1:0] {
      WM_READ_FIRST  = 2'h0,
      WM_WRITE_FIRST = 2'h1,
      WM_NO_CHANGE   = 2'h2
   } bram_wmode_t;

   typedef struct packed {
      logic        en;
      logic        we;
      logic [14:0] addr;
      logic [71:0] din;
   } bram_req_t;

   typedef struct packed {
      bram_width_t width;
      bram_wmode_t wmode;
   } bram_pcfg_t;

   typedef struct packed {
      logic [8:0]  idx;
      logic [5:0]  dsh;
      logic [63:0] dmask;
      logic [2:0]  psh;
      logic [7:0]  pmask;
   } bram_map_t;

endpackage

/* src/bram_ecc.sv */
// SEC-DED encoder and decoder for 64 data bits and 8 check bits
`timescale 1ns/10ps
module bram_ecc (
   // Encoder
   input  wire logic [63:0] i_data,
   output logic      [7:0]  o_check,
   // Decoder
   input  wire logic [71:0] i_word,
   output logic      [63:0] o_data,
   output logic             o_sbit,
   output logic             o_dbit
);
   import bram_pkg::*;

   // ==========================================================
   // Encode: data fills non power of two code positions
   always_comb begin
      logic [71:0] cw;
      logic [6:0]  pe;
      int          j;
      cw = '0;
      pe = '0;
      j  = 0;
      for (int pos = 1; pos < WORD_W; pos++) begin
         if ((pos & (pos - 1)) != 0) begin
            cw[pos] = i_data[j];
            j++;
         end
      end
      for (int pos = 1; pos < WORD_W; pos++) begin
         for (int k = 0; k < 7; k++) begin
            if (pos[k]) begin
               pe[k] = pe[k] ^ cw[pos];
            end
         end
      end
      o_check = {(^i_data) ^ (^pe), pe};
   end

   // ==========================================================
   // Decode: syndrome plus overall parity
   always_comb begin
      logic [71:0] dw;
      logic [6:0]  s;
      logic        ov;
      int          j;
      dw = '0;
      s  = '0;
      j  = 0;
      for (int pos = 1; pos < WORD_W; pos++) begin
         if ((pos & (pos - 1)) != 0) begin
            dw[pos] = i_word[j];
            j++;
         end
      end
      for (int k = 0; k < 7; k++) begin
         dw[1 << k] = i_word[DATA_W + k];
      end
      for (int pos = 1; pos < WORD_W; pos++) begin
         for (int k = 0; k < 7; k++) begin
            if (pos[k]) begin
               s[k] = s[k] ^ dw[pos];
            end
         end
      end
      ov = (^dw) ^ i_word[71];
      if (ov && s != 7'h0 && s < 7'd72) begin
         dw[s] = ~dw[s];
      end
      o_sbit = ov;
      o_dbit = (s != 7'h0) && !ov;
      j = 0;
      o_data = '0;
      for (int pos = 1; pos < WORD_W; pos++) begin
         if ((pos & (pos - 1)) != 0) begin
            o_data[j] = dw[pos];
            j++;
         end
      end
   end

endmodule // bram_ecc

/* src/bram_fifo_ctl.sv */
// Queue pointer and flag controller for the block memory
`timescale 1ns/10ps
module bram_fifo_ctl (
   // Clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_rstn,
   // Configuration
   input  wire logic        i_enable,
   input  wire logic [6:0]  i_wbits,
   input  wire logic [6:0]  i_rbits,
   input  wire logic [14:0] i_wmask,
   input  wire logic [14:0] i_rmask,
   input  wire logic [15:0] i_cap,
   input  wire logic [15:0] i_afull_lvl,
   input  wire logic [15:0] i_aempty_lvl,
   // Requests
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic             o_wr_ok,
   output logic             o_rd_ok,
   output logic      [14:0] o_waddr,
   output logic      [14:0] o_raddr,
   // Flags
   output logic             o_full,
   output logic             o_empty,
   output logic             o_afull,
   output logic             o_aempty
);
   import bram_pkg::*;

   logic [15:0] lvl_q;
   logic [15:0] lvl_d;

   // Requests against a full or empty queue are dropped
   assign o_wr_ok = i_wr & ~o_full;
   assign o_rd_ok = i_rd & ~o_empty;

   always_comb begin
      lvl_d = lvl_q;
      if (o_wr_ok) begin
         lvl_d = lvl_d + {9'h0, i_wbits};
      end
      if (o_rd_ok) begin
         lvl_d = lvl_d - {9'h0, i_rbits};
      end
   end

   // ==========================================================
   // Pointers advance by themselves
   always_ff @(posedge i_clk) begin
      if (!i_rstn || !i_enable) begin
         o_waddr <= PTR_RST;
         o_raddr <= PTR_RST;
         lvl_q   <= LVL_RST;
      end else begin
         if (o_wr_ok) begin
            o_waddr <= (o_waddr + 15'h1) & i_wmask;
         end
         if (o_rd_ok) begin
            o_raddr <= (o_raddr + 15'h1) & i_rmask;
         end
         lvl_q <= lvl_d;
      end
   end

   // ==========================================================
   // Flags
   always_ff @(posedge i_clk) begin
      if (!i_rstn || !i_enable) begin
         o_full   <= 1'b0;
         o_empty  <= 1'b1;
         o_afull  <= 1'b0;
         o_aempty <= 1'b1;
      end else begin
         o_full   <= ({1'b0, lvl_d} + {10'h0, i_wbits})
                     > {1'b0, i_cap};
         o_empty  <= lvl_d < {9'h0, i_rbits};
         o_afull  <= lvl_d >= i_afull_lvl;
         o_aempty <= lvl_d <= i_aempty_lvl;
      end
   end

endmodule // bram_fifo_ctl

/* src/bram_top.sv */
// Dual-port block memory with split, wide, ECC and queue modes
`timescale 1ns/10ps
module bram_top (
   // Clock and reset
   input  wire logic                 i_clk,
   input  wire logic                 i_rstn,
   // Configuration
   input  wire logic                 i_split_halves,
   input  wire logic                 i_split_read_write_mode,
   input  wire logic                 i_fifo_mode,
   input  wire logic                 i_ecc_en,
   input  wire logic                 i_addr_latch_off,
   input  wire logic                 i_out_reg_en,
   input  wire bram_pkg::bram_pcfg_t i_cfg_a,
   input  wire bram_pkg::bram_pcfg_t i_cfg_b,
   // Power
   input  wire logic                 i_block_used,
   input  wire logic                 i_power_down,
   // Ports
   input  wire bram_pkg::bram_req_t  i_req_a,
   input  wire bram_pkg::bram_req_t  i_req_b,
   // Cascade
   input  wire logic                 i_casc_sel,
   input  wire logic [71:0]          i_casc_din,
   // Queue thresholds
   input  wire logic [15:0]          i_afull_lvl,
   input  wire logic [15:0]          i_aempty_lvl,
   // Standalone code engine
   input  wire logic [63:0]          i_xecc_data,
   input  wire logic [71:0]          i_xecc_word,
   // Read data
   output logic      [71:0]          o_dout_a,
   output logic      [71:0]          o_dout_b,
   output logic      [71:0]          o_casc_dout,
   output logic                      o_sbit_err,
   output logic                      o_dbit_err,
   // Queue flags
   output logic                      o_full,
   output logic                      o_empty,
   output logic                      o_afull,
   output logic                      o_aempty,
   // Standalone code engine results
   output logic      [7:0]           o_xecc_check,
   output logic      [63:0]          o_xecc_data,
   output logic                      o_xecc_sbit,
   output logic                      o_xecc_dbit,
   // Power state
   output logic                      o_powered
);
   import bram_pkg::*;

   // ==========================================================
   // Functions
   function automatic bram_width_t eff_width(
      bram_width_t w, logic split_read_write_mode, logic split, logic wr_side);
      bram_width_t mx;
      mx = split ? (split_read_write_mode ? BW_36 : BW_18)
                 : (split_read_write_mode ? BW_72 : BW_36);
      if (split_read_write_mode && wr_side) begin
         return mx;
      end
      return (w > mx) ? mx : w;
   endfunction

   function automatic logic [6:0] width_bits(bram_width_t w);
      case (w)
         BW_1:    return 7'd1;
         BW_2:    return 7'd2;
         BW_4:    return 7'd4;
         BW_9:    return 7'd9;
         BW_18:   return 7'd18;
         BW_36:   return 7'd36;
         default: return 7'd72;
      endcase
   endfunction

   function automatic logic [14:0] ptr_mask(bram_width_t w,
                                            logic split);
      int lg;
      if (w <= BW_4) begin
         lg = NARROW_LOG - int'(w);
      end else begin
         lg = BYTE_LOG - (int'(w) - 3);
      end
      lg = lg - int'(split);
      return 15'((32'h1 << lg) - 32'h1);
   endfunction

   function automatic bram_map_t map_addr(bram_width_t w,
                                          logic [14:0] a);
      bram_map_t   m;
      logic [14:0] p;
      logic [2:0]  b;
      int          k;
      m = '0;
      if (w <= BW_4) begin
         k       = int'(w);
         p       = a << k;
         m.idx   = p[14:6];
         m.dsh   = p[5:0];
         m.dmask = (64'h1 << (1 << k)) - 64'h1;
      end else begin
         k       = int'(w) - 3;
         p       = a >> (3 - k);
         b       = 3'(a[2:0] << k);
         m.idx   = p[8:0];
         m.psh   = b;
         m.dsh   = {b, 3'h0};
         m.dmask = (64'h1 << (8 << k)) - 64'h1;
         m.pmask = 8'((9'h1 << (1 << k)) - 9'h1);
      end
      return m;
   endfunction

   function automatic logic [71:0] merge_word(logic [71:0] w,
      logic [71:0] d, bram_map_t m);
      logic [63:0] dd;
      logic [7:0]  pp;
      dd = (w[63:0] & ~(m.dmask << m.dsh))
           | ((d[63:0] & m.dmask) << m.dsh);
      pp = (w[71:64] & ~(m.pmask << m.psh))
           | ((d[71:64] & m.pmask) << m.psh);
      return {pp, dd};
   endfunction

   function automatic logic [71:0] extract(logic [71:0] w,
                                           bram_map_t m);
      return {(w[71:64] >> m.psh) & m.pmask,
              (w[63:0] >> m.dsh) & m.dmask};
   endfunction

   // ==========================================================
   // Declarations
   bram_req_t   req_in  [2];
   bram_req_t   req_q   [2];
   bram_pcfg_t  cfg     [2];
   bram_width_t wid     [2];
   bram_map_t   mp      [2];
   logic [71:0] mem_q   [0:511];
   logic [71:0] old_w   [2];
   logic [71:0] wdat    [2];
   logic [71:0] mrg     [2];
   logic [71:0] rv      [2];
   logic [71:0] stage_q [2];
   logic [71:0] dout_q  [2];
   logic        wr_go   [2];
   logic        rd_go   [2];
   logic        upd     [2];
   logic        act_q;
   logic        split_read_write_mode;
   logic        ecc_on;
   logic [7:0]  enc_chk;
   logic [63:0] dec_data;
   logic        dec_s;
   logic        dec_d;
   logic [1:0]  err_rv;
   logic [1:0]  err_stage_q;
   logic [1:0]  err_q;
   logic [7:0]  x_chk;
   logic [63:0] x_data;
   logic        x_s;
   logic        x_d;
   logic        f_wr_ok;
   logic        f_rd_ok;
   logic [14:0] f_waddr;
   logic [14:0] f_raddr;
   logic [15:0] f_cap;

   assign req_in[0] = i_req_a;
   assign req_in[1] = i_req_b;
   assign cfg[0]    = i_cfg_a;
   assign cfg[1]    = i_cfg_b;
   assign split_read_write_mode       = i_split_read_write_mode | i_fifo_mode;
   assign ecc_on    = i_ecc_en & i_split_read_write_mode
                      & ~i_split_halves;
   assign f_cap     = (wid[0] <= BW_4 ? CAP_NARROW : CAP_BYTE)
                      >> i_split_halves;

   // ==========================================================
   // Power gating
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         act_q <= 1'b0;
      end else begin
         act_q <= i_block_used & ~i_power_down;
      end
   end

   // ==========================================================
   // Input registers
   always_ff @(posedge i_clk) begin
      for (int p = 0; p < 2; p++) begin
         if (!i_rstn) begin
            req_q[p] <= '0;
         end else begin
            req_q[p].en  <= req_in[p].en & act_q;
            req_q[p].we  <= req_in[p].we;
            req_q[p].din <= req_in[p].din;
            if (req_in[p].en || i_addr_latch_off) begin
               req_q[p].addr <= req_in[p].addr;
            end
         end
      end
   end

   // ==========================================================
   // Address mapping and access decisions
   always_comb begin
      logic [14:0] addr;
      addr = '0;
      for (int p = 0; p < 2; p++) begin
         wid[p] = eff_width(cfg[p].width, split_read_write_mode, i_split_halves,
                            p == 0);
         if (i_fifo_mode) begin
            addr = (p == 0) ? f_waddr : f_raddr;
         end else begin
            addr = req_q[p].addr;
         end
         mp[p] = map_addr(wid[p], addr);
         if (i_split_halves) begin
            mp[p].idx = {(i_fifo_mode ? 1'b0 : p[0]),
                         mp[p].idx[7:0]};
         end
         old_w[p] = mem_q[mp[p].idx];
         wdat[p]  = req_q[p].din;
         if (p == 0 && ecc_on) begin
            wdat[p][71:64] = enc_chk;
         end
         mrg[p] = merge_word(old_w[p], wdat[p], mp[p]);
         if (i_fifo_mode) begin
            wr_go[p] = (p == 0) && f_wr_ok;
            rd_go[p] = (p == 1) && f_rd_ok;
         end else if (split_read_write_mode) begin
            wr_go[p] = (p == 0) && req_q[p].en
                       && req_q[p].we;
            rd_go[p] = (p == 1) && req_q[p].en;
         end else begin
            wr_go[p] = req_q[p].en && req_q[p].we;
            rd_go[p] = req_q[p].en && !req_q[p].we;
         end
      end
   end

   // ==========================================================
   // Read value per port
   always_comb begin
      for (int p = 0; p < 2; p++) begin
         rv[p]  = extract(old_w[p], mp[p]);
         upd[p] = rd_go[p];
         if (wr_go[p]) begin
            case (cfg[p].wmode)
               WM_READ_FIRST: begin
                  upd[p] = 1'b1;
               end
               WM_WRITE_FIRST: begin
                  rv[p]  = extract(mrg[p], mp[p]);
                  upd[p] = 1'b1;
               end
               default: begin
                  upd[p] = rd_go[p];
               end
            endcase
         end
      end
      err_rv = 2'b00;
      if (rd_go[1] && ecc_on && wid[1] == BW_72) begin
         rv[1]  = {old_w[1][71:64], dec_data};
         err_rv = {dec_s, dec_d};
      end
      if (i_casc_sel && req_q[1].en) begin
         rv[1]  = i_casc_din;
         upd[1] = 1'b1;
         err_rv = 2'b00;
      end
   end

   // ==========================================================
   // Array writes, port B last
   always_ff @(posedge i_clk) begin
      for (int p = 0; p < 2; p++) begin
         if (act_q && wr_go[p]) begin
            mem_q[mp[p].idx] <= mrg[p];
         end
      end
   end

   // ==========================================================
   // Output latch and optional pipeline register
   always_ff @(posedge i_clk) begin
      for (int p = 0; p < 2; p++) begin
         if (!i_rstn) begin
            stage_q[p] <= DOUT_RST;
            dout_q[p]  <= DOUT_RST;
         end else if (act_q) begin
            if (upd[p]) begin
               stage_q[p] <= rv[p];
            end
            if (i_out_reg_en) begin
               dout_q[p] <= stage_q[p];
            end else if (upd[p]) begin
               dout_q[p] <= rv[p];
            end
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         err_stage_q <= 2'b00;
         err_q       <= 2'b00;
      end else if (act_q) begin
         if (upd[1]) begin
            err_stage_q <= err_rv;
         end
         if (i_out_reg_en) begin
            err_q <= err_stage_q;
         end else if (upd[1]) begin
            err_q <= err_rv;
         end
      end
   end

   assign o_dout_a    = dout_q[0];
   assign o_dout_b    = dout_q[1];
   assign o_casc_dout = dout_q[1];
   assign o_sbit_err  = err_q[1];
   assign o_dbit_err  = err_q[0];
   assign o_powered   = act_q;

   // ==========================================================
   // Standalone code engine, registered
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         o_xecc_check <= CHK_RST;
         o_xecc_data  <= XDATA_RST;
         o_xecc_sbit  <= 1'b0;
         o_xecc_dbit  <= 1'b0;
      end else begin
         o_xecc_check <= x_chk;
         o_xecc_data  <= x_data;
         o_xecc_sbit  <= x_s;
         o_xecc_dbit  <= x_d;
      end
   end

   // ==========================================================
   // Instances
   bram_ecc u_ecc (
      .i_data  (req_q[0].din[63:0]),
      .o_check (enc_chk),
      .i_word  (old_w[1]),
      .o_data  (dec_data),
      .o_sbit  (dec_s),
      .o_dbit  (dec_d)
   );

   bram_ecc u_xecc (
      .i_data  (i_xecc_data),
      .o_check (x_chk),
      .i_word  (i_xecc_word),
      .o_data  (x_data),
      .o_sbit  (x_s),
      .o_dbit  (x_d)
   );

   bram_fifo_ctl u_fifo (
      .i_clk        (i_clk),
      .i_rstn       (i_rstn),
      .i_enable     (i_fifo_mode),
      .i_wbits      (width_bits(wid[0])),
      .i_rbits      (width_bits(wid[1])),
      .i_wmask      (ptr_mask(wid[0], i_split_halves)),
      .i_rmask      (ptr_mask(wid[1], i_split_halves)),
      .i_cap        (f_cap),
      .i_afull_lvl  (i_afull_lvl),
      .i_aempty_lvl (i_aempty_lvl),
      .i_wr         (act_q & req_q[0].en & req_q[0].we),
      .i_rd         (act_q & req_q[1].en),
      .o_wr_ok      (f_wr_ok),
      .o_rd_ok      (f_rd_ok),
      .o_waddr      (f_waddr),
      .o_raddr      (f_raddr),
      .o_full       (o_full),
      .o_empty      (o_empty),
      .o_afull      (o_afull),
      .o_aempty     (o_aempty)
   );

endmodule // bram_top

/* testbench/bram_chk.sv */
// Port checker for the dual-port block memory
`timescale 1ns/10ps
module bram_chk (
   // Clock, reset and power
   input wire logic                i_clk,
   input wire logic                i_rstn,
   input wire logic                i_block_used,
   input wire logic                i_power_down,
   input wire logic                o_powered,
   // Requests and data
   input wire bram_pkg::bram_req_t i_req_a,
   input wire bram_pkg::bram_req_t i_req_b,
   input wire logic [71:0]         o_dout_b,
   input wire logic [71:0]         o_casc_dout,
   // Queue flags
   input wire logic                o_full,
   input wire logic                o_empty,
   input wire logic                o_aempty,
   // Standalone code engine
   input wire logic [63:0]         i_xecc_data,
   input wire logic [71:0]         i_xecc_word,
   input wire logic [7:0]          o_xecc_check,
   input wire logic [63:0]         o_xecc_data,
   input wire logic                o_xecc_sbit,
   input wire logic                o_xecc_dbit
);
   logic wr_req;
   logic rd_req;
   assign wr_req = i_req_a.en & i_req_a.we;
   assign rd_req = i_req_b.en;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rstn);
   a_power_on: assert property ((i_block_used && !i_power_down) |=> o_powered)
      else $error("block not powered while in use");
   a_power_off: assert property (!(i_block_used && !i_power_down) |=> !o_powered)
      else $error("block powered while gated");
   a_casc_mirror: assert property (o_casc_dout == o_dout_b)
      else $error("cascade output differs from port B");
   a_reset_flags: assert property ($rose(i_rstn) |-> o_empty && o_aempty && !o_full && !o_powered)
      else $error("wrong flags out of reset");
   a_empty_low: assert property (o_empty |-> o_aempty)
      else $error("empty without almost empty");
   a_empty_fall: assert property ($fell(o_empty) |-> $past(wr_req, 2))
      else $error("empty cleared without a write");
   a_full_rise: assert property ($rose(o_full) |-> $past(wr_req, 2))
      else $error("full set without a write");
   a_empty_rise: assert property ($rose(o_empty) |-> $past(rd_req, 2))
      else $error("empty set without a read");
   a_xecc_clean: assert property (($stable(i_xecc_data) && i_xecc_word == {o_xecc_check, i_xecc_data})
      |=> !o_xecc_sbit && !o_xecc_dbit && o_xecc_data == $past(i_xecc_data))
      else $error("clean code word not passed through");
endmodule // bram_chk

bind bram_top bram_chk u_bram_chk (.i_clk(i_clk), .i_rstn(i_rstn),
   .i_block_used(i_block_used), .i_power_down(i_power_down),
   .o_powered(o_powered), .i_req_a(i_req_a), .i_req_b(i_req_b),
   .o_dout_b(o_dout_b), .o_casc_dout(o_casc_dout), .o_full(o_full),
   .o_empty(o_empty), .o_aempty(o_aempty), .i_xecc_data(i_xecc_data),
   .i_xecc_word(i_xecc_word), .o_xecc_check(o_xecc_check),
   .o_xecc_data(o_xecc_data), .o_xecc_sbit(o_xecc_sbit),
   .o_xecc_dbit(o_xecc_dbit));

/* testbench/bram_user.sv */
// User logic model issuing requests on both memory ports
`timescale 1ns/10ps
module bram_user (
   // Clock and queue status
   input  wire logic           i_clk,
   input  wire logic           i_full,
   input  wire logic           i_empty,
   // Requests
   output bram_pkg::bram_req_t o_req_a,
   output bram_pkg::bram_req_t o_req_b
);
   import bram_pkg::*;
   initial begin
      o_req_a = '0;
      o_req_b = '0;
   end
   // Hold one request per port from a falling edge to the next
   task automatic put(input logic ea, eb, we, input logic [14:0] ad,
                      input logic [71:0] d);
      o_req_a = '{ea, we, ad, d};
      o_req_b = '{eb, 1'b0, ad, ~d};
      @(negedge i_clk);
   endtask
   // Queue traffic never writes while full or reads while empty
   task automatic qput(input logic wr, rd, input logic [71:0] d);
      put(wr && !i_full, rd && !i_empty, 1'b1, 15'h0, d);
   endtask
endmodule // bram_user

/* testbench/bram_top_bench.sv */
// Self-checking bench for the dual-port block memory
`timescale 1ns/10ps
module bram_top_bench;
   import bram_pkg::*;
   localparam logic [71:0] M36 = 72'h0f_0000_0000_ffff_ffff;
   logic i_clk = 1'b0, i_rstn = 1'b0, i_split_halves = 1'b0;
   logic i_split_read_write_mode = 1'b0, i_fifo_mode = 1'b0;
   logic i_ecc_en = 1'b0, i_addr_latch_off = 1'b0, i_out_reg_en = 1'b0;
   logic i_casc_sel = 1'b0, i_block_used = 1'b1, i_power_down = 1'b0;
   bram_pcfg_t  i_cfg_a = '{BW_36, WM_READ_FIRST};
   bram_pcfg_t  i_cfg_b = '{BW_36, WM_READ_FIRST};
   bram_req_t   i_req_a, i_req_b;
   logic [71:0] i_casc_din = 72'h5a_0123_4567_89ab_cdef;
   logic [71:0] i_xecc_word = 72'h0, o_dout_a, o_dout_b;
   logic [15:0] i_afull_lvl = 16'h8ca0, i_aempty_lvl = 16'h0048;
   logic [63:0] i_xecc_data = 64'h0, o_xecc_data;
   logic [7:0]  o_xecc_check;
   logic o_full, o_empty, o_afull, o_aempty, o_xecc_sbit, o_xecc_dbit;
   logic o_powered;
   int   num_errors = 0, check_count = 0;
   bram_top u_bram_top (.i_clk, .i_rstn, .i_split_halves,
      .i_split_read_write_mode, .i_fifo_mode, .i_ecc_en, .i_addr_latch_off,
      .i_out_reg_en, .i_cfg_a, .i_cfg_b, .i_block_used, .i_power_down,
      .i_req_a, .i_req_b, .i_casc_sel, .i_casc_din, .i_afull_lvl,
      .i_aempty_lvl, .i_xecc_data, .i_xecc_word, .o_dout_a, .o_dout_b,
      .o_casc_dout(), .o_sbit_err(), .o_dbit_err(), .o_full, .o_empty,
      .o_afull, .o_aempty, .o_xecc_check, .o_xecc_data, .o_xecc_sbit,
      .o_xecc_dbit, .o_powered);
   bram_user u_bram_user (.i_clk, .i_full(o_full), .i_empty(o_empty),
      .o_req_a(i_req_a), .o_req_b(i_req_b));
   always #12.5 i_clk = ~i_clk;
   // ==========================================================
   // Helpers
   task automatic chk(input logic [71:0] got, exp);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic flags(input logic [3:0] e);
      chk(72'({o_full, o_empty, o_afull, o_aempty}), 72'(e));
   endtask
   task automatic idle(input int n);
      repeat (n) u_bram_user.put(0, 0, 0, 15'h0, 72'h0);
   endtask
   task automatic close_out();
      $display("Checks %0d, mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // ==========================================================
   // Scenarios
   task automatic wmodes();
      logic [71:0] v0, v1, w, e[3];
      w = 72'h03_0000_0000_cafe_0004;
      v1 = 72'h0a_0000_0000_8765_4321;
      u_bram_user.put(1, 0, 1, 15'h4, w);
      for (int m = 0; m < 3; m++) begin
         v0 = 72'h05_0000_0000_1234_5670 + 72'(m);
         e = '{v0, v1, w};
         i_cfg_a.wmode = bram_wmode_t'(m);
         u_bram_user.put(1, 0, 1, 15'h3, v0);
         u_bram_user.put(1, 0, 0, 15'h4, 72'h0);
         u_bram_user.put(1, 0, 1, 15'h3, v1);
         idle(1);
         chk(o_dout_a & M36, e[m]);
      end
      u_bram_user.put(0, 1, 0, 15'h3, 72'h0);
      idle(1);
      chk(o_dout_b & M36, v1);
   endtask
   task automatic outreg();
      i_out_reg_en = 1'b1;
      u_bram_user.put(0, 1, 0, 15'h3, 72'h0);
      idle(2);
      u_bram_user.put(0, 1, 0, 15'h4, 72'h0);
      idle(1);
      chk(o_dout_b & M36, 72'h0a_0000_0000_8765_4321);
      idle(1);
      chk(o_dout_b & M36, 72'h03_0000_0000_cafe_0004);
      i_casc_sel = 1'b1;
      u_bram_user.put(0, 1, 0, 15'h4, 72'h0);
      idle(2);
      chk(o_dout_b, i_casc_din);
      i_casc_sel = 1'b0;
      i_out_reg_en = 1'b0;
   endtask
   task automatic queue();
      i_fifo_mode = 1'b1;
      idle(2);
      flags(4'b0101);
      // Write side runs at the fixed 72 bit width, read side at 36
      for (int i = 0; i < 512; i++) begin
         u_bram_user.qput(1, 0, 72'(i) | (72'(i) << 32));
         if (i < 3 || i == 498 || i == 499 || i >= 510) begin
            idle(1);
            flags({i == 511, 1'b0, i >= 499, i < 1});
         end
      end
      u_bram_user.put(1, 0, 1, 15'h0, 72'hff);
      idle(1);
      flags(4'b1010);
      for (int i = 0; i < 1024; i++) begin
         u_bram_user.qput(0, 1, 72'h0);
         if (i > 0) chk(o_dout_b & M36, 72'((i - 1) >> 1));
      end
      idle(1);
      chk(o_dout_b & M36, 72'h1ff);
      u_bram_user.put(0, 1, 0, 15'h0, 72'h0);
      idle(1);
      chk(o_dout_b & M36, 72'h1ff);
      flags(4'b0101);
      i_fifo_mode = 1'b0;
   endtask
   task automatic ecc();
      logic [63:0] d;
      logic [7:0]  c;
      d = 64'h0123_4567_89ab_cdef;
      i_xecc_data = d;
      @(negedge i_clk);
      c = o_xecc_check;
      i_xecc_word = {c, d ^ 64'h20};
      @(negedge i_clk);
      chk(72'({o_xecc_sbit, o_xecc_dbit, o_xecc_data}), 72'({2'b10, d}));
      i_xecc_word = {c, d ^ 64'h60};
      @(negedge i_clk);
      chk(72'({o_xecc_sbit, o_xecc_dbit}), 72'h1);
      i_xecc_word = {c, d};
      @(negedge i_clk);
      chk(72'({o_xecc_sbit, o_xecc_dbit, o_xecc_data}), 72'(d));
   endtask
   task automatic power();
      i_power_down = 1'b1;
      idle(1);
      chk(72'(o_powered), 72'h0);
      i_power_down = 1'b0;
      i_block_used = 1'b0;
      idle(1);
      chk(72'(o_powered), 72'h0);
      i_block_used = 1'b1;
      idle(1);
      chk(72'(o_powered), 72'h1);
   endtask
   // ==========================================================
   // Main sequence and watchdog
   initial begin
      #200000;
      num_errors++;
      close_out();
   end
   initial begin
      repeat (20) @(negedge i_clk);
      i_rstn = 1'b1;
      idle(2);
      wmodes();
      outreg();
      queue();
      ecc();
      power();
      close_out();
   end
endmodule // bram_top_bench
